/* verilog/dmc_defines.svh */
/*
 constant names for the mode control register bank: word layout, indices,
 field positions, reset values and step timing. assumes inclusion by bare name.
*/
`ifndef DMC_DEFINES_SVH
`define DMC_DEFINES_SVH

`define DMC_WORD_BITS      16
`define DMC_CNT_BITS       5
`define DMC_ZERO_BIT       15
`define DMC_IDX_HI         14
`define DMC_IDX_LO         8
`define DMC_DATA_HI        7
`define DMC_DATA_LO        0

`define DMC_IDX_LEFT       7'h01
`define DMC_IDX_RIGHT      7'h02
`define DMC_IDX_FORMAT     7'h03
`define DMC_IDX_ZCPD       7'h04

`define DMC_RIGHT_MUTE_BIT 7
`define DMC_LEFT_MUTE_BIT  6
`define DMC_ATTEN_HI       5
`define DMC_ATTEN_LO       0
`define DMC_OVER_BIT       7
`define DMC_RIGHT_POLARITY_INVERT_BIT       5
`define DMC_ANALOG_MIX_ENABLE_BIT       4
`define DMC_DEM_BIT        3
`define DMC_FMT_HI         2
`define DMC_FMT_LO         0
`define DMC_ZERO_CROSS_ENABLE_BIT       4
`define DMC_LOW_POWER_REQUEST_BIT       0

`define DMC_ATTEN_RESET    6'h3f
`define DMC_ATTEN_MUTE     6'h00
`define DMC_FMT_RESET      3'h0

`define DMC_STEP_SAMPLES   8
`define DMC_ZC_TIMEOUT     512

`endif

/* verilog/dmc_pkg.sv */
/*
 types shared by the mode control register bank.
 assumes nothing beyond a SystemVerilog compiler.
*/
package dmc_pkg;

   typedef enum logic [0:0] {
      PORT_IDLE  = 1'b0,
      PORT_SHIFT = 1'b1
   } dmc_port_t;

   typedef enum logic [2:0] {
      FMT_LEFT_JUST   = 3'b000,
      FMT_I2S         = 3'b001,
      FMT_RIGHT_24    = 3'b010,
      FMT_RIGHT_20    = 3'b011,
      FMT_RIGHT_16    = 3'b100,
      FMT_LEFT_MASTER = 3'b101
   } dmc_format_t;

endpackage

/* verilog/dmc_regs.sv */
/*
 mode control register bank of a stereo dac: serial control port receiver,
 four write-only registers and the stepped attenuation/mute ramp per channel.
 assumes: control port pins are asynchronous and much slower than clock;
 sample_strobe and the zero-cross pulses come from audio logic on clock.
*/
// Functional notes
// - bits shift on shift clock rise while frame low; frame rise ends word.
// - indices 01h to 04h select the register that takes the data byte.
// - register 01 bit 7 right mute, bit 6 left mute, both reset 0.
// - mute set ramps the channel down 1 dB per step to mute.
// - mute cleared ramps the channel back up to its programmed level.
// - code 3f is 0 dB, each lower code 1 dB more, 00 is mute.
// - applied level moves one step each eight sample periods toward target.
// - left code in register 01 bits 5:0, right in register 02 bits 5:0.
// - register 03 bit 7 oversampling select, 0 at reset.
// - register 03 bit 5 inverts right output, reset 0.
// - register 03 bit 4 enables analog input mixing, reset 0.
// - register 03 bit 3 enables 44.1 kHz de-emphasis, reset 0.
// - register 03 bits 2:0 select audio format, 000 at reset.
// - register 04 bit 4 makes level steps wait for zero crossings.
// - in zero-cross mode a step waits at most 512 sample periods.
// - zero crossings watched per channel; one channel steps per cycle, ties alternate left and right.
// - register 04 bit 0 powers down, resets the ramp logic but keeps registers.
`timescale 1ns/10ps
`include "dmc_defines.svh"

module dmc_regs
   import dmc_pkg::*;
#(
   parameter int STEP_SAMPLES = `DMC_STEP_SAMPLES,
   parameter int ZC_TIMEOUT   = `DMC_ZC_TIMEOUT
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       ctrl_shift_clock,
   input  wire logic       ctrl_frame_select_n,
   input  wire logic       ctrl_serial_in,
   input  wire logic       sample_strobe,
   input  wire logic       left_zero_cross,
   input  wire logic       right_zero_cross,
   output logic [5:0]      left_applied_level,
   output logic [5:0]      right_applied_level,
   output logic            oversample_select,
   output logic            right_polarity_invert,
   output logic            analog_mix_enable,
   output logic            deemphasis_enable,
   output logic [2:0]      audio_format_select,
   output logic            zero_cross_enable,
   output logic            low_power_request
);

   localparam int STEP_W = $clog2(STEP_SAMPLES);
   localparam int ZC_W   = $clog2(ZC_TIMEOUT);
   localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_SAMPLES - 1);
   localparam logic [ZC_W-1:0]   ZC_LAST   = ZC_W'(ZC_TIMEOUT - 1);

   // pin synchronisers: stage one feeds stage two only
   logic [2:0] pin_meta_reg;
   logic [2:0] pin_meta_next;
   logic [2:0] pin_sync_reg;
   logic [2:0] pin_sync_next;
   logic [1:0] pin_last_reg;
   logic [1:0] pin_last_next;

   always_comb begin
      pin_meta_next = {ctrl_serial_in, ctrl_frame_select_n, ctrl_shift_clock};
      pin_sync_next = pin_meta_reg;
      pin_last_next = pin_sync_reg[1:0];
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         // idle pin levels, so no false shift or frame edge follows reset
         pin_meta_reg <= 3'h2;
         pin_sync_reg <= 3'h2;
         pin_last_reg <= 2'h2;
      end else begin
         pin_meta_reg <= pin_meta_next;
         pin_sync_reg <= pin_sync_next;
         pin_last_reg <= pin_last_next;
      end
   end

   logic sclk_rise;
   logic frame_low;
   logic frame_rise;
   logic data_bit;

   always_comb begin
      sclk_rise  = pin_sync_reg[0] & ~pin_last_reg[0];
      frame_low  = ~pin_sync_reg[1];
      frame_rise = pin_sync_reg[1] & ~pin_last_reg[1];
      data_bit   = pin_sync_reg[2];
   end

   // serial receiver
   dmc_port_t                    port_state_reg;
   dmc_port_t                    port_state_next;
   logic [`DMC_WORD_BITS-1:0]    shift_reg;
   logic [`DMC_WORD_BITS-1:0]    shift_next;
   logic [`DMC_CNT_BITS-1:0]     bit_cnt_reg;
   logic [`DMC_CNT_BITS-1:0]     bit_cnt_next;
   logic                         word_done;

   always_comb begin
      port_state_next = port_state_reg;
      shift_next      = shift_reg;
      bit_cnt_next    = bit_cnt_reg;
      word_done       = 1'b0;
      case (port_state_reg)
         PORT_IDLE: begin
            // count restarts on every frame, so a cut frame leaves nothing behind
            if (frame_low) begin
               port_state_next = PORT_SHIFT;
               bit_cnt_next    = '0;
            end
         end
         PORT_SHIFT: begin
            if (frame_rise) begin
               // short or long frames are dropped, not half-decoded
               word_done       = (bit_cnt_reg == `DMC_CNT_BITS'(`DMC_WORD_BITS));
               port_state_next = PORT_IDLE;
            end else if (sclk_rise) begin
               shift_next = {shift_reg[`DMC_WORD_BITS-2:0], data_bit};
               if (bit_cnt_reg != `DMC_CNT_BITS'(`DMC_WORD_BITS + 1)) begin
                  bit_cnt_next = bit_cnt_reg + 1'b1;
               end
            end
         end
         default: begin
            port_state_next = PORT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         port_state_reg <= PORT_IDLE;
         shift_reg      <= '0;
         bit_cnt_reg    <= '0;
      end else begin
         port_state_reg <= port_state_next;
         shift_reg      <= shift_next;
         bit_cnt_reg    <= bit_cnt_next;
      end
   end

   // register bank
   // write-only: no read path, reserved bits never reach a port
   logic [7:0] left_mute_and_attenuation_reg;
   logic [7:0] left_mute_and_attenuation_next;
   logic [7:0] right_attenuation_reg;
   logic [7:0] right_attenuation_next;
   logic [7:0] format_and_analog_options_reg;
   logic [7:0] format_and_analog_options_next;
   logic [7:0] zero_cross_and_power_down_reg;
   logic [7:0] zero_cross_and_power_down_next;
   logic [6:0] register_index;
   logic [7:0] wr_data;
   logic       wr_ok;

   always_comb begin
      register_index = shift_reg[`DMC_IDX_HI:`DMC_IDX_LO];
      wr_data        = shift_reg[`DMC_DATA_HI:`DMC_DATA_LO];
      // reserved bits are stored as written; host keeps them zero
      wr_ok          = word_done & ~shift_reg[`DMC_ZERO_BIT];
      left_mute_and_attenuation_next = left_mute_and_attenuation_reg;
      right_attenuation_next         = right_attenuation_reg;
      format_and_analog_options_next = format_and_analog_options_reg;
      zero_cross_and_power_down_next = zero_cross_and_power_down_reg;
      if (wr_ok) begin
         case (register_index)
            `DMC_IDX_LEFT:   left_mute_and_attenuation_next = wr_data;
            `DMC_IDX_RIGHT:  right_attenuation_next = wr_data;
            `DMC_IDX_FORMAT: format_and_analog_options_next = wr_data;
            `DMC_IDX_ZCPD:   zero_cross_and_power_down_next = wr_data;
            default: begin
               // any other index leaves every register as it was
               left_mute_and_attenuation_next = left_mute_and_attenuation_reg;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         left_mute_and_attenuation_reg <= {2'h0, `DMC_ATTEN_RESET};
         right_attenuation_reg         <= {2'h0, `DMC_ATTEN_RESET};
         format_and_analog_options_reg <= {5'h00, `DMC_FMT_RESET};
         zero_cross_and_power_down_reg <= 8'h00;
      end else begin
         left_mute_and_attenuation_reg <= left_mute_and_attenuation_next;
         right_attenuation_reg         <= right_attenuation_next;
         format_and_analog_options_reg <= format_and_analog_options_next;
         zero_cross_and_power_down_reg <= zero_cross_and_power_down_next;
      end
   end

   always_comb begin
      oversample_select     = format_and_analog_options_reg[`DMC_OVER_BIT];
      right_polarity_invert = format_and_analog_options_reg[`DMC_RIGHT_POLARITY_INVERT_BIT];
      analog_mix_enable     = format_and_analog_options_reg[`DMC_ANALOG_MIX_ENABLE_BIT];
      deemphasis_enable     = format_and_analog_options_reg[`DMC_DEM_BIT];
      audio_format_select   = format_and_analog_options_reg[`DMC_FMT_HI:`DMC_FMT_LO];
      zero_cross_enable     = zero_cross_and_power_down_reg[`DMC_ZERO_CROSS_ENABLE_BIT];
      low_power_request     = zero_cross_and_power_down_reg[`DMC_LOW_POWER_REQUEST_BIT];
   end

   // attenuation ramp, index 0 left, 1 right
   logic [5:0]        target [2];
   logic [5:0]        level_reg [2];
   logic [5:0]        level_next [2];
   logic [ZC_W-1:0]   zc_wait_reg [2];
   logic [ZC_W-1:0]   zc_wait_next [2];
   logic [STEP_W-1:0] step_cnt_reg;
   logic [STEP_W-1:0] step_cnt_next;
   logic              turn_reg;
   logic              turn_next;
   logic              step_due;
   logic [1:0]        pending;
   logic [1:0]        zc_go;
   logic [1:0]        do_step;
   logic [1:0]        zc_seen;

   always_comb begin
      zc_seen   = {right_zero_cross, left_zero_cross};
      // mute overrides the code but the code stays stored for the return
      target[0] = left_mute_and_attenuation_reg[`DMC_LEFT_MUTE_BIT] ? `DMC_ATTEN_MUTE
                  : left_mute_and_attenuation_reg[`DMC_ATTEN_HI:`DMC_ATTEN_LO];
      target[1] = left_mute_and_attenuation_reg[`DMC_RIGHT_MUTE_BIT] ? `DMC_ATTEN_MUTE
                  : right_attenuation_reg[`DMC_ATTEN_HI:`DMC_ATTEN_LO];
      step_due  = sample_strobe & (step_cnt_reg == STEP_LAST);
      // free-running, so a new target waits at most eight strobes
      step_cnt_next = step_cnt_reg;
      if (sample_strobe) begin
         step_cnt_next = (step_cnt_reg == STEP_LAST) ? '0 : step_cnt_reg + 1'b1;
      end
      for (int c = 0; c < 2; c++) begin
         pending[c]      = (level_reg[c] != target[c]);
         zc_go[c]        = pending[c] & (zc_seen[c] |
                           (sample_strobe & (zc_wait_reg[c] == ZC_LAST)));
         zc_wait_next[c] = zc_wait_reg[c];
      end
      if (zero_cross_enable) begin
         // one channel per cycle; the other waits for its turn
         do_step[0] = zc_go[0] & (~turn_reg | ~zc_go[1]);
         do_step[1] = zc_go[1] & (turn_reg | ~zc_go[0]);
      end else begin
         do_step = pending & {2{step_due}};
      end
      // ties go left first after reset or power-down, then alternate
      turn_next = turn_reg;
      if (do_step[0]) begin
         turn_next = 1'b1;
      end
      if (do_step[1]) begin
         turn_next = 1'b0;
      end
      for (int c = 0; c < 2; c++) begin
         level_next[c] = level_reg[c];
         if (do_step[c]) begin
            // one code is one 1 dB step; 00 is mute
            level_next[c] = (level_reg[c] < target[c]) ? level_reg[c] + 1'b1
                            : level_reg[c] - 1'b1;
            zc_wait_next[c] = '0;
         end else if (!zero_cross_enable || !pending[c]) begin
            zc_wait_next[c] = '0;
         end else if (sample_strobe && zc_wait_reg[c] != ZC_LAST) begin
            // holds at the limit: a channel that lost its turn falls back next strobe
            zc_wait_next[c] = zc_wait_reg[c] + 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst || low_power_request) begin
         // power-down restarts the ramp from mute so leaving it is pop-free
         level_reg[0]   <= `DMC_ATTEN_MUTE;
         level_reg[1]   <= `DMC_ATTEN_MUTE;
         zc_wait_reg[0] <= '0;
         zc_wait_reg[1] <= '0;
         step_cnt_reg   <= '0;
         turn_reg       <= 1'b0;
      end else begin
         level_reg[0]   <= level_next[0];
         level_reg[1]   <= level_next[1];
         zc_wait_reg[0] <= zc_wait_next[0];
         zc_wait_reg[1] <= zc_wait_next[1];
         step_cnt_reg   <= step_cnt_next;
         turn_reg       <= turn_next;
      end
   end

   always_comb begin
      left_applied_level  = level_reg[0];
      right_applied_level = level_reg[1];
   end

endmodule

/* test/dmc_regs_asserts.sv */
/*
 port checker for the mode control register bank.
 assumes it is bound onto dmc_regs and sees only its ports.
*/
`timescale 1ns/10ps
module dmc_regs_asserts #(
   parameter int STEP_SAMPLES = 8,
   parameter int ZC_TIMEOUT   = 512
) (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       ctrl_shift_clock,
   input wire logic       ctrl_frame_select_n,
   input wire logic       ctrl_serial_in,
   input wire logic       sample_strobe,
   input wire logic       left_zero_cross,
   input wire logic       right_zero_cross,
   input wire logic [5:0] left_applied_level,
   input wire logic [5:0] right_applied_level,
   input wire logic       oversample_select,
   input wire logic       right_polarity_invert,
   input wire logic       analog_mix_enable,
   input wire logic       deemphasis_enable,
   input wire logic [2:0] audio_format_select,
   input wire logic       zero_cross_enable,
   input wire logic       low_power_request
);
   logic [9:0] phase_reg;
   logic [9:0] phase_next;
   logic       lp_d_reg;
   logic       lp_d_next;
   logic       zc_d_reg;
   logic       zc_d_next;
   logic       quiet;
   // own strobe phase; power-down restarts it like the device's counter
   always_comb begin
      phase_next = phase_reg;
      if (rst || low_power_request) begin
         phase_next = 10'h000;
      end else if (sample_strobe) begin
         phase_next = (phase_reg == STEP_SAMPLES - 1) ? 10'h000 : phase_reg + 10'h001;
      end
      lp_d_next = low_power_request;
      zc_d_next = zero_cross_enable;
      quiet = !low_power_request && !lp_d_reg;
   end
   always_ff @(posedge clock) begin
      phase_reg <= phase_next;
      lp_d_reg  <= lp_d_next;
      zc_d_reg  <= zc_d_next;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_reset_values: assert property (disable iff (1'b0) rst |=>
      {oversample_select, right_polarity_invert, analog_mix_enable, deemphasis_enable,
      audio_format_select, zero_cross_enable, low_power_request} == 9'h000)
      else $error("settings not cleared by reset");
   a_left_step_size: assert property (quiet && $changed(left_applied_level) |->
      left_applied_level - $past(left_applied_level) inside {6'h01, 6'h3f})
      else $error("left level moved by more than one step");
   a_right_step_size: assert property (quiet && $changed(right_applied_level) |->
      right_applied_level - $past(right_applied_level) inside {6'h01, 6'h3f})
      else $error("right level moved by more than one step");
   a_left_step_phase: assert property (quiet && !zero_cross_enable && !zc_d_reg
      && $changed(left_applied_level) |-> $past(sample_strobe)
      && $past(phase_reg) == STEP_SAMPLES - 1)
      else $error("left step off the strobe grid");
   a_right_step_phase: assert property (quiet && !zero_cross_enable && !zc_d_reg
      && $changed(right_applied_level) |-> $past(sample_strobe)
      && $past(phase_reg) == STEP_SAMPLES - 1)
      else $error("right step off the strobe grid");
   a_power_down_mute: assert property (low_power_request |=>
      left_applied_level == 6'h00 && right_applied_level == 6'h00)
      else $error("levels not muted in power down");
   a_zc_one_side: assert property (quiet && zero_cross_enable && zc_d_reg |->
      !($changed(left_applied_level) && $changed(right_applied_level)))
      else $error("both channels stepped together");
   a_zc_left_cause: assert property (quiet && zero_cross_enable && zc_d_reg
      && $changed(left_applied_level) |-> $past(left_zero_cross) || $past(sample_strobe))
      else $error("left step without zero cross or timeout");
   a_zc_right_cause: assert property (quiet && zero_cross_enable && zc_d_reg
      && $changed(right_applied_level) |-> $past(right_zero_cross) || $past(sample_strobe))
      else $error("right step without zero cross or timeout");
   a_cfg_after_frame: assert property ($changed({oversample_select,
      right_polarity_invert, analog_mix_enable, deemphasis_enable, audio_format_select,
      zero_cross_enable, low_power_request}) |-> ctrl_frame_select_n
      && $past(ctrl_frame_select_n))
      else $error("setting changed inside a frame");
endmodule

/* test/dmc_host_model.sv */
/*
 host model driving the three-wire control port.
 assumes the device samples these pins with its own clock.
*/
`timescale 1ns/10ps
module dmc_host_model (
   output logic ctrl_shift_clock,
   output logic ctrl_frame_select_n,
   output logic ctrl_serial_in
);
   initial begin
      ctrl_shift_clock = 1'b0;
      ctrl_frame_select_n = 1'b1;
      ctrl_serial_in = 1'b0;
   end
   // shift clock stands low outside frames; half sets prompt or slow host
   task automatic send(input logic [15:0] word, input int nbits, input int half);
      int i;
      #(half / 3);
      ctrl_frame_select_n = 1'b0;
      for (i = 0; i < nbits; i++) begin
         ctrl_serial_in = word[15 - i];
         #half ctrl_shift_clock = 1'b1;
         #half ctrl_shift_clock = 1'b0;
      end
      ctrl_frame_select_n = 1'b1;
      ctrl_serial_in = ~ctrl_serial_in; // stale bit would hide a late sample
      #(6 * half);
   endtask
endmodule

/* test/testbench.sv */
/*
 self-checking bench for the mode control register bank.
 assumes dmc_regs, the host model and the checker are compiled first.
*/
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
   $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module testbench;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic       sample_strobe = 1'b0;
   logic       left_zero_cross = 1'b0;
   logic       right_zero_cross = 1'b0;
   logic       zc_on = 1'b0;
   wire logic  sck;
   wire logic  fs_n;
   wire logic  sdi;
   logic [5:0] ll;
   logic [5:0] rl;
   logic [2:0] fm;
   logic       os, ri, am, de, ze, lp;
   logic [5:0] lc, rc;
   logic [7:0] r3;
   int         seed = 41;
   int         bad_count = 0;
   int         num_checks = 0;
   int         i;
   always #50 clock = ~clock;
   dmc_host_model host (.ctrl_shift_clock(sck), .ctrl_frame_select_n(fs_n),
      .ctrl_serial_in(sdi));
   // short zero-cross timeout keeps the fallback path cheap to reach
   dmc_regs #(.ZC_TIMEOUT(16)) dut (.clock(clock), .rst(rst), .ctrl_shift_clock(sck),
      .ctrl_frame_select_n(fs_n), .ctrl_serial_in(sdi), .sample_strobe(sample_strobe),
      .left_zero_cross(left_zero_cross), .right_zero_cross(right_zero_cross),
      .left_applied_level(ll), .right_applied_level(rl), .oversample_select(os),
      .right_polarity_invert(ri), .analog_mix_enable(am), .deemphasis_enable(de),
      .audio_format_select(fm), .zero_cross_enable(ze), .low_power_request(lp));
   always @(posedge clock) begin
      #1;
      sample_strobe = 1'($random(seed));
      left_zero_cross = zc_on && ($random(seed) % 7 == 0);
      right_zero_cross = zc_on && ($random(seed) % 7 == 0);
   end
   // expected setting outputs from the words last written to registers 03 and 04
   function automatic logic [8:0] cfg_of(input logic [7:0] f, input logic [7:0] z);
      return {f[7], f[5:0], z[4], z[0]};
   endfunction
   task automatic wr(input logic [6:0] idx, input logic [7:0] data);
      host.send({1'b0, idx, data}, 16, 400);
   endtask
   task automatic settle(input logic [5:0] el, input logic [5:0] er);
      int n;
      for (n = 0; n < 9000 && (ll !== el || rl !== er); n++) begin
         @(posedge clock);
         #2;
      end
      `CHK("left level", el, ll)
      `CHK("right level", er, rl)
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #(100 * 95000);
      bad_count++;
      final_report;
   end
   initial begin
      repeat (20) @(posedge clock);
      #1 rst = 1'b0;
      @(posedge clock);
      #2;
      `CHK("reset cfg", cfg_of(8'h00, 8'h00), {os, ri, am, de, fm, ze, lp})
      `CHK("reset level", 12'h000, {ll, rl})
      settle(6'h3f, 6'h3f);
      // format codes 110 and 111 are reserved, so the host never sends them
      for (i = 0; i < 6; i++) begin
         r3 = 8'($random(seed)) & 8'hbf;
         r3[2:0] = 3'(i);
         wr(7'h03, r3);
         `CHK("oversample", r3[7], os)
         `CHK("invert", r3[5], ri)
         `CHK("mix", r3[4], am)
         `CHK("deemph", r3[3], de)
         `CHK("format", r3[2:0], fm)
      end
      host.send({1'b0, 7'h00, 8'hff}, 16, 1200);
      host.send({1'b0, 7'h05, 8'hff}, 16, 400);
      host.send({1'b0, 7'h7f, 8'hff}, 16, 400);
      host.send({1'b1, 7'h03, 8'h40}, 16, 400);
      host.send({1'b0, 7'h03, 8'h00}, 15, 400);
      `CHK("refused", cfg_of(r3, 8'h00), {os, ri, am, de, fm, ze, lp})
      for (i = 0; i < 4; i++) begin
         lc = (i == 0) ? 6'h01 : 6'($random(seed));
         rc = (i == 1) ? 6'h00 : 6'($random(seed));
         wr(7'h01, {2'b00, lc});
         wr(7'h02, {2'b00, rc});
         settle(lc, rc);
      end
      wr(7'h01, {2'b10, lc});
      settle(lc, 6'h00);
      wr(7'h01, {2'b01, lc});
      settle(6'h00, rc);
      wr(7'h04, 8'h10);
      `CHK("zero cross", 1'b1, ze)
      zc_on = 1'b1;
      wr(7'h01, 8'h3f);
      wr(7'h02, 8'h05);
      settle(6'h3f, 6'h05);
      zc_on = 1'b0;
      wr(7'h01, 8'h30);
      settle(6'h30, 6'h05);
      r3[7] = 1'b1;
      r3[5] = 1'b0;
      wr(7'h03, r3);
      `CHK("oversample", 1'b1, os)
      `CHK("invert", 1'b0, ri)
      wr(7'h04, 8'h01);
      `CHK("pd level", 13'h1000, {lp, ll, rl})
      `CHK("kept", cfg_of(r3, 8'h01), {os, ri, am, de, fm, ze, lp})
      wr(7'h04, 8'h00);
      settle(6'h30, 6'h05);
      final_report;
   end
endmodule
bind dmc_regs dmc_regs_asserts #(.STEP_SAMPLES(STEP_SAMPLES), .ZC_TIMEOUT(ZC_TIMEOUT)) chk (
   .clock(clock), .rst(rst), .ctrl_shift_clock(ctrl_shift_clock),
   .ctrl_frame_select_n(ctrl_frame_select_n), .ctrl_serial_in(ctrl_serial_in),
   .sample_strobe(sample_strobe), .left_zero_cross(left_zero_cross),
   .right_zero_cross(right_zero_cross), .left_applied_level(left_applied_level),
   .right_applied_level(right_applied_level), .oversample_select(oversample_select),
   .right_polarity_invert(right_polarity_invert), .analog_mix_enable(analog_mix_enable),
   .deemphasis_enable(deemphasis_enable), .audio_format_select(audio_format_select),
   .zero_cross_enable(zero_cross_enable), .low_power_request(low_power_request));
